//--- inc/hdf_pkg.sv
// Purpose: constants and types of the hd component video formatter
// Assumes: 10-bit 4:2:2 words, one sample per clock
// Notes:   line numbers count from 1, sample index from 0
package hdf_pkg;
   localparam int W_DATA   = 10;
   localparam int W_H      = 12;
   localparam int W_V      = 11;
   localparam int FIFO_DEP = 8;
   // -------------------------------------------
   // word values
   // -------------------------------------------
   localparam logic [9:0] TRS_ONE  = 10'h3ff;
   localparam logic [9:0] TRS_ZERO = 10'h000;
   localparam logic [9:0] Y_MIN    = 10'h040;
   localparam logic [9:0] Y_MAX    = 10'h3ac;
   localparam logic [9:0] C_MIN    = 10'h040;
   localparam logic [9:0] C_MAX    = 10'h3c0;
   localparam logic [9:0] Y_BLANK  = 10'h040;
   localparam logic [9:0] C_BLANK  = 10'h200;
   localparam int         TRS_LEN  = 4;
   // -------------------------------------------
   // xyz bit positions
   // -------------------------------------------
   localparam int XYZ_ONE = 9;
   localparam int XYZ_F   = 8;
   localparam int XYZ_V   = 7;
   localparam int XYZ_H   = 6;
   // -------------------------------------------
   // format select codes
   // -------------------------------------------
   typedef enum logic [2:0] {
      HDF_1035I      = 3'h0,
      HDF_1080I_1250 = 3'h1,
      HDF_1080I_2200 = 3'h2,
      HDF_1080I_2640 = 3'h3,
      HDF_1080P_2200 = 3'h4,
      HDF_1080P_2640 = 3'h5,
      HDF_1080P_2750 = 3'h6,
      HDF_720P       = 3'h7
   } hdf_sel_type;
   typedef struct packed {
      logic [11:0] h_tot;
      logic [11:0] h_act;
      logic [10:0] v_tot;
      logic [10:0] f2_start;
      logic [10:0] a1_s;
      logic [10:0] a1_e;
      logic [10:0] a2_s;
      logic [10:0] a2_e;
   } hdf_fmt_type;
   // -------------------------------------------
   // raster of each format: totals, active, field two, active line spans
   // -------------------------------------------
   localparam hdf_fmt_type FMT_1035I      =
      '{12'd2200, 12'd1920, 11'd1125, 11'd563, 11'd41, 11'd557, 11'd603, 11'd1120};
   localparam hdf_fmt_type FMT_1080I_1250 =
      '{12'd2376, 12'd1920, 11'd1250, 11'd626, 11'd81, 11'd620, 11'd706, 11'd1245};
   localparam hdf_fmt_type FMT_1080I_2200 =
      '{12'd2200, 12'd1920, 11'd1125, 11'd563, 11'd21, 11'd560, 11'd584, 11'd1123};
   localparam hdf_fmt_type FMT_1080I_2640 =
      '{12'd2640, 12'd1920, 11'd1125, 11'd563, 11'd21, 11'd560, 11'd584, 11'd1123};
   localparam hdf_fmt_type FMT_1080P_2200 =
      '{12'd2200, 12'd1920, 11'd1125, 11'd1126, 11'd42, 11'd1121, 11'd0, 11'd0};
   localparam hdf_fmt_type FMT_1080P_2640 =
      '{12'd2640, 12'd1920, 11'd1125, 11'd1126, 11'd42, 11'd1121, 11'd0, 11'd0};
   localparam hdf_fmt_type FMT_1080P_2750 =
      '{12'd2750, 12'd1920, 11'd1125, 11'd1126, 11'd42, 11'd1121, 11'd0, 11'd0};
   localparam hdf_fmt_type FMT_720P       =
      '{12'd1650, 12'd1280, 11'd750, 11'd751, 11'd26, 11'd745, 11'd0, 11'd0};
endpackage : hdf_pkg

//--- rtl/hdf_formatter.sv
// Purpose: 4:2:2 hd component stream with eav/sav, luma and chroma channels
// Assumes: picture inputs come from logic on ref_clk_in, format select from a pin
// Notes:   picture words are clamped so sync words never appear in them
// Function
// RQ1: each timing reference is four words
// RQ2: reference opens 3ff, 000, 000
// RQ3: fourth word carries field, vblank, eav/sav flags
// RQ4: sync triple appears only in references
// RQ5: luma kept within 64 to 940
// RQ6: chroma kept within 64 to 960
// RQ7: chroma word alternates cb, cr per sample
// RQ8: each chroma component at half sample rate
// RQ9: separate 10-bit luma and chroma channels
// RQ10: eav ends active, sav starts active
// RQ11: interlaced fields sent one after another
// RQ12: progressive lines sent top to bottom
// RQ13: segmented frame timed as interlaced
// RQ14: 1080 line rasters 2200/2640/2750 by 1125
// RQ15: 720p raster 1650 by 750
// RQ16: 1080i 1250 line raster 2376 wide
// RQ17: 1035i active inside 2200 by 1125
// RQ18: system switches clock for /m rates
// RQ19: one word pair per clock, no gaps
// RQ20: xyz bits in the standard layout
`timescale 1ns/1ps

module hdf_fifo #(
   parameter int WIDTH = 20,
   parameter int DEPTH = 8
) (
   input  wire logic             ref_clk_in,
   input  wire logic             rst_n_in,
   input  wire logic             wr_valid_in,
   output logic                  wr_ready_out,
   input  wire logic [WIDTH-1:0] wr_data_in,
   output logic                  rd_valid_out,
   input  wire logic             rd_ready_in,
   output logic      [WIDTH-1:0] rd_data_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   assign wr_ready_out = (count != (AW+1)'(DEPTH));
   assign rd_valid_out = (count != '0);
   assign push         = wr_valid_in && wr_ready_out;
   assign pop          = rd_valid_out && rd_ready_in;
   assign rd_data_out  = mem[rd_ptr];

   always_ff @(posedge ref_clk_in) begin
      if (push) begin
         mem[wr_ptr] <= wr_data_in;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   a_fifo_full_stop : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      count == (AW+1)'(DEPTH) |-> !wr_ready_out && rd_valid_out)
      else $error("fifo full but still accepting");
endmodule : hdf_fifo

module hdf_formatter (
   input  wire logic                       ref_clk_in,
   input  wire logic                       rst_n_in,
   input  wire logic [2:0]                 fmt_sel_in,
   input  wire logic [hdf_pkg::W_DATA-1:0] pic_y_in,
   input  wire logic [hdf_pkg::W_DATA-1:0] pic_cb_in,
   input  wire logic [hdf_pkg::W_DATA-1:0] pic_cr_in,
   output logic                            pic_take_out,
   output logic [hdf_pkg::W_H-1:0]         pixel_out,
   output logic [hdf_pkg::W_V-1:0]         line_out,
   input  wire logic                       vid_ready_in,
   output logic                            vid_valid_out,
   output logic [hdf_pkg::W_DATA-1:0]      vid_y_out,
   output logic [hdf_pkg::W_DATA-1:0]      vid_c_out
);
   // -------------------------------------------
   // format table
   // -------------------------------------------
   function automatic hdf_pkg::hdf_fmt_type fmt_of(input logic [2:0] sel);
      hdf_pkg::hdf_fmt_type f;
      f = hdf_pkg::FMT_1080I_2200;
      case (hdf_pkg::hdf_sel_type'(sel))
         hdf_pkg::HDF_1035I: begin
            f = hdf_pkg::FMT_1035I; // RQ17
         end
         hdf_pkg::HDF_1080I_1250: begin
            f = hdf_pkg::FMT_1080I_1250; // RQ16
         end
         hdf_pkg::HDF_1080I_2640: begin
            f = hdf_pkg::FMT_1080I_2640; // RQ14
         end
         hdf_pkg::HDF_1080P_2200: begin
            f = hdf_pkg::FMT_1080P_2200; // RQ12
         end
         hdf_pkg::HDF_1080P_2640: begin
            f = hdf_pkg::FMT_1080P_2640; // RQ14
         end
         hdf_pkg::HDF_1080P_2750: begin
            f = hdf_pkg::FMT_1080P_2750; // RQ14
         end
         hdf_pkg::HDF_720P: begin
            f = hdf_pkg::FMT_720P; // RQ15
         end
         default: begin
            f = hdf_pkg::FMT_1080I_2200; // 1080i and sF share the 2200 raster
         end
      endcase
      return f;
   endfunction : fmt_of

   function automatic logic [9:0] clamp(input logic [9:0] v, input logic [9:0] lo, input logic [9:0] hi);
      return (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction : clamp

   // -------------------------------------------
   // raster counters
   // -------------------------------------------
   hdf_pkg::hdf_fmt_type fmt;
   logic [2:0]           sel;
   logic [11:0]          h;
   logic [10:0]          ln;
   logic                 accept;
   logic                 fifo_ready;
   logic                 fld;
   logic                 vblank;
   logic                 active;
   logic                 eav;
   logic                 sav;
   logic [1:0]           trs_idx;
   logic [9:0]           xyz;
   logic [9:0]           next_y;
   logic [9:0]           next_c;

   assign fmt    = fmt_of(sel);
   assign accept = fifo_ready; // RQ19
   assign fld    = (ln >= fmt.f2_start); // RQ11 RQ13
   assign vblank = !((ln >= fmt.a1_s && ln <= fmt.a1_e) || (ln >= fmt.a2_s && ln <= fmt.a2_e));
   assign active = (h < fmt.h_act);
   assign eav    = (h >= fmt.h_act) && (h < fmt.h_act + 12'(hdf_pkg::TRS_LEN)); // RQ10
   assign sav    = (h >= fmt.h_tot - 12'(hdf_pkg::TRS_LEN)); // RQ10
   assign trs_idx = eav ? 2'(h - fmt.h_act) : 2'(h - (fmt.h_tot - 12'(hdf_pkg::TRS_LEN)));

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         h <= '0;
      end else if (accept) begin
         h <= (h == fmt.h_tot - 12'd1) ? '0 : h + 12'd1;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ln <= 11'd1;
      end else if (accept && h == fmt.h_tot - 12'd1) begin
         ln <= (ln == fmt.v_tot) ? 11'd1 : ln + 11'd1; // RQ11 RQ12
      end
   end

   // -------------------------------------------
   // format select synchroniser
   // -------------------------------------------
   logic [2:0]           sel_meta;
   logic [2:0]           sel_sync;
   logic [2:0]           sel_last;

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sel_meta <= 3'h0;
         sel_sync <= 3'h0;
         sel_last <= 3'h0;
      end else begin
         sel_meta <= fmt_sel_in;
         sel_sync <= sel_meta;
         sel_last <= sel_sync;
      end
   end

   // format changes only at frame start, and only once settled
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sel <= 3'h0;
      end else if (accept && h == fmt.h_tot - 12'd1 && ln == fmt.v_tot && sel_sync == sel_last) begin
         sel <= sel_sync;
      end
   end

   // -------------------------------------------
   // word build
   // -------------------------------------------
   always_comb begin
      xyz          = '0;
      xyz[hdf_pkg::XYZ_ONE] = 1'b1; // RQ20
      xyz[hdf_pkg::XYZ_F]   = fld; // RQ3
      xyz[hdf_pkg::XYZ_V]   = vblank; // RQ3
      xyz[hdf_pkg::XYZ_H]   = eav; // RQ3
      xyz[5]       = vblank ^ eav;
      xyz[4]       = fld ^ eav;
      xyz[3]       = fld ^ vblank;
      xyz[2]       = fld ^ vblank ^ eav; // RQ20
      next_y       = hdf_pkg::Y_BLANK;
      next_c       = hdf_pkg::C_BLANK;
      if (eav || sav) begin
         case (trs_idx) // RQ1 RQ2
            2'd0: begin
               next_y = hdf_pkg::TRS_ONE;
               next_c = hdf_pkg::TRS_ONE;
            end
            2'd3: begin
               next_y = xyz;
               next_c = xyz;
            end
            default: begin
               next_y = hdf_pkg::TRS_ZERO;
               next_c = hdf_pkg::TRS_ZERO;
            end
         endcase
      end else if (active && !vblank) begin
         next_y = clamp(pic_y_in, hdf_pkg::Y_MIN, hdf_pkg::Y_MAX); // RQ5 RQ4
         next_c = h[0] ? clamp(pic_cr_in, hdf_pkg::C_MIN, hdf_pkg::C_MAX) // RQ7 RQ8
                       : clamp(pic_cb_in, hdf_pkg::C_MIN, hdf_pkg::C_MAX); // RQ6
      end
   end

   assign pic_take_out = accept && active && !vblank;
   assign pixel_out    = h;
   assign line_out     = ln;

   // -------------------------------------------
   // output buffer
   // -------------------------------------------
   logic [19:0] rd_word;

   hdf_fifo #(
      .WIDTH (2*hdf_pkg::W_DATA),
      .DEPTH (hdf_pkg::FIFO_DEP)
   ) u_fifo (
      .ref_clk_in   (ref_clk_in),
      .rst_n_in     (rst_n_in),
      .wr_valid_in  (1'b1),
      .wr_ready_out (fifo_ready),
      .wr_data_in   ({next_y, next_c}),
      .rd_valid_out (vid_valid_out),
      .rd_ready_in  (vid_ready_in),
      .rd_data_out  (rd_word)
   );

   assign vid_y_out = rd_word[19:10]; // RQ9
   assign vid_c_out = rd_word[9:0]; // RQ9

   // -------------------------------------------
   // last two pushed words, for the sync check
   // -------------------------------------------
   logic [9:0]           prev1_y;
   logic [9:0]           prev2_y;
   logic [9:0]           prev1_c;
   logic [9:0]           prev2_c;

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         prev1_y <= '0;
         prev2_y <= '0;
         prev1_c <= '0;
         prev2_c <= '0;
      end else if (accept) begin
         prev1_y <= next_y;
         prev2_y <= prev1_y;
         prev1_c <= next_c;
         prev2_c <= prev1_c;
      end
   end

   // -------------------------------------------
   // checks
   // -------------------------------------------
   a_trs_lead_word : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RQ2
      (h == fmt.h_act || h == fmt.h_tot - 12'd4) |-> next_y == 10'h3ff && next_c == 10'h3ff)
      else $error("reference does not open with 3ff");
   a_trs_zero_pair : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RQ1
      (eav || sav) && (trs_idx == 2'd1 || trs_idx == 2'd2) |-> next_y == 10'h000 && next_c == 10'h000)
      else $error("reference words two and three not zero");
   a_xyz_eav_flag : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RQ3
      (eav || sav) && trs_idx == 2'd3 |-> next_y[9] && next_y[6] == eav && next_y[8] == fld
      && next_y[7] == vblank)
      else $error("xyz flags wrong");
   a_sync_only_trs : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RQ4
      !(eav || sav) |-> next_y != 10'h3ff && next_c != 10'h3ff && next_y != 10'h000
      && next_c != 10'h000)
      else $error("sync word outside a reference");
   a_luma_range : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RQ5
      active |-> next_y >= 10'd64 && next_y <= 10'd940)
      else $error("luma out of range");
   a_chroma_range : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RQ6
      active |-> next_c >= 10'd64 && next_c <= 10'd960)
      else $error("chroma out of range");
   a_chroma_alt : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RQ7
      accept && active && h[0] == 1'b0 && h != fmt.h_tot - 12'd1 |=> h[0] == 1'b1)
      else $error("chroma phase did not alternate");
   a_line_wrap : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RQ12
      accept && h == fmt.h_tot - 12'd1 && ln == fmt.v_tot |=> ln == 11'd1 && h == 12'd0)
      else $error("frame did not wrap to line one");
   a_field_order : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RQ11
      accept && fmt.f2_start <= fmt.v_tot && h == fmt.h_tot - 12'd1 && ln == fmt.f2_start - 11'd1
      |=> fld && ln == $past(ln) + 11'd1)
      else $error("second field did not follow first");
   a_sync_triple_y : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RQ4
      accept && prev2_y == 10'h3ff && prev1_y == 10'h000 && next_y == 10'h000 |-> (eav || sav) && trs_idx == 2'd2)
      else $error("luma sync triple outside a reference");
   a_sync_triple_c : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RQ4
      accept && prev2_c == 10'h3ff && prev1_c == 10'h000 && next_c == 10'h000 |-> (eav || sav) && trs_idx == 2'd2)
      else $error("chroma sync triple outside a reference");
   a_xyz_protect_bits : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RQ20
      (eav || sav) && trs_idx == 2'd3 |-> next_y[5] == (next_y[7] ^ next_y[6]) && next_y[4] == (next_y[8] ^ next_y[6])
      && next_y[3] == (next_y[8] ^ next_y[7]) && next_y[2] == ^next_y[8:6] && next_y[1:0] == 2'h0 && next_c == next_y)
      else $error("xyz protection bits wrong");
   a_eav_at_active : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RQ10
      h == fmt.h_act |-> eav && !sav && trs_idx == 2'd0)
      else $error("eav not at end of active");
   a_vid_head_hold : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RQ9
      vid_valid_out && !vid_ready_in |=> vid_valid_out && $stable(vid_y_out) && $stable(vid_c_out))
      else $error("output words changed before taken");
   a_ready_accept : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RQ19
      vid_ready_in |=> accept)
      else $error("generator stalled while downstream ready");
   a_pixel_bound : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RQ14
      h < fmt.h_tot)
      else $error("sample index beyond line total");
   a_line_bound : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // RQ14
      ln >= 11'd1 && ln <= fmt.v_tot)
      else $error("line number beyond frame total");
endmodule : hdf_formatter

//--- tb/hdf_formatter_tb.sv
// Purpose: self-checking bench of the formatter in its first frame
// Assumes: format 0 runs the first frame whatever fmt_sel_in says
// Notes:   every accepted word pair is compared against the raster
`timescale 1ns/1ps
module hdf_formatter_tb;
   logic        clk;
   logic        rst_n;
   logic [1:0]  mode;
   logic [9:0]  pic_y;
   logic [9:0]  pic_cb;
   logic [9:0]  pic_cr;
   logic [9:0]  vy;
   logic [9:0]  vc;
   logic [11:0] pix;
   logic [11:0] hold_pix;
   logic [10:0] lin;
   logic        take;
   logic        ready;
   logic        valid;
   logic [19:0] w;
   int          fails;
   int          cmp_count;
   int          cyc;
   int          eh;
   int          el;
   bit          started;
   // ----------------------------
   // clock, design and far side
   // ----------------------------
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   hdf_formatter DUT (.ref_clk_in(clk), .rst_n_in(rst_n), .fmt_sel_in(3'h7), .pic_y_in(pic_y),
      .pic_cb_in(pic_cb), .pic_cr_in(pic_cr), .pic_take_out(take), .pixel_out(pix), .line_out(lin),
      .vid_ready_in(ready), .vid_valid_out(valid), .vid_y_out(vy), .vid_c_out(vc));
   hdf_sink u_sink (.ref_clk_in(clk), .rst_n_in(rst_n), .mode_in(mode), .vid_ready_out(ready));
   // ----------------------------
   // expected words
   // ----------------------------
   function automatic logic [9:0] raw(input int h, input int k);
      return 10'(h * k);
   endfunction : raw
   function automatic logic [9:0] clampv(input logic [9:0] v, input logic [9:0] hi);
      return (v < 10'h040) ? 10'h040 : ((v > hi) ? hi : v);
   endfunction : clampv
   function automatic logic [19:0] exp_word(input int h, input int l);
      logic       act;
      logic       f;
      logic       v;
      logic       e;
      logic [9:0] x;
      int         i;
      act = (l >= 41 && l <= 557) || (l >= 603 && l <= 1120);
      f = (l >= 563);
      v = !act;
      e = (h < 2196);
      if ((h >= 1920 && h <= 1923) || h >= 2196) begin
         i = e ? h - 1920 : h - 2196;
         x = {1'b1, f, v, e, v ^ e, f ^ e, f ^ v, f ^ v ^ e, 2'h0};
         x = (i == 0) ? 10'h3ff : ((i == 3) ? x : 10'h000);
         return {x, x};
      end
      if (h < 1920 && act) begin
         return {clampv(raw(h, 37), 10'h3ac), clampv(h[0] ? ~raw(h, 53) : raw(h, 53), 10'h3c0)};
      end
      return {10'h040, 10'h200};
   endfunction : exp_word
   // ----------------------------
   // compare, report, timeout
   // ----------------------------
   task automatic check(input string name, input logic [19:0] seen, input logic [19:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic results;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : results
   always @(posedge clk) begin
      cyc++;
      if (cyc == 95000) begin
         fails++;
         results();
      end
   end
   always @(posedge clk) begin
      #1;
      pic_y  = raw(int'(pix), 37);
      pic_cb = raw(int'(pix), 53);
      pic_cr = ~raw(int'(pix), 53);
   end
   always @(negedge clk) begin
      if (rst_n && started) begin
         check("valid", 20'(valid), 20'h1);
      end
      if (rst_n && valid && ready) begin
         w = exp_word(eh, el);
         check("luma", 20'(vy), 20'(w[19:10]));
         check("chroma", 20'(vc), 20'(w[9:0]));
         started = 1'b1;
         eh++;
         if (eh == 2200) begin
            eh = 0;
            el++;
         end
      end
   end
   // ----------------------------
   // scenarios
   // ----------------------------
   task automatic test_reset;
      repeat (5) @(posedge clk);
      check("valid in reset", 20'(valid), 20'h0);
      #1 rst_n = 1'b1;
      @(posedge clk);
      @(negedge clk);
      check("valid after reset", 20'(valid), 20'h1);
      $display("test reset done");
   endtask : test_reset
   task automatic test_blank_lines;
      while (el < 41) @(posedge clk);
      #1 check("line reached", 20'(lin), 20'd41);
      check("take on active line", 20'(take), 20'h1);
      $display("test blank lines done");
   endtask : test_blank_lines
   task automatic test_stall;
      @(posedge clk);
      #1 mode = 2'h2;
      repeat (12) @(posedge clk);
      #1 hold_pix = pix;
      repeat (8) @(posedge clk);
      #1 check("pixel held", 20'(pix), 20'(hold_pix));
      check("no take when full", 20'(take), 20'h0);
      mode = 2'h1;
      repeat (300) @(posedge clk);
      #1 mode = 2'h0;
      $display("test stall done");
   endtask : test_stall
   task automatic test_active_line;
      while (el < 42) @(posedge clk);
      $display("test active line done");
   endtask : test_active_line
   initial begin
      rst_n  = 1'b0;
      mode   = 2'h0;
      pic_y  = 10'h000;
      pic_cb = 10'h000;
      pic_cr = 10'h000;
      el     = 1;
      test_reset();
      test_blank_lines();
      test_stall();
      test_active_line();
      results();
   end
endmodule : hdf_formatter_tb

//--- tb/hdf_sink.sv
// Purpose: downstream encoder model that accepts the word stream
// Assumes: mode 0 prompt, 1 every other cycle, 2 withheld
// Notes:   ready changes only on the rising edge
`timescale 1ns/1ps
module hdf_sink (
   input  wire logic       ref_clk_in,
   input  wire logic       rst_n_in,
   input  wire logic [1:0] mode_in,
   output logic            vid_ready_out
);
   logic phase;
   // ----------------------------
   // ready pattern
   // ----------------------------
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         phase         <= 1'b0;
         vid_ready_out <= 1'b0;
      end else begin
         phase         <= ~phase;
         vid_ready_out <= (mode_in == 2'h0) | ((mode_in == 2'h1) & phase);
      end
   end
endmodule : hdf_sink
